// File: common/wsfm_regs.vh
`ifndef WSFM_REGS_VH
`define WSFM_REGS_VH

// Register byte offsets on the plain register port
`define WSFM_OFS_DEV_CFG 8'h00
`define WSFM_OFS_OP_MODE 8'h04
`define WSFM_OFS_ACC_SEL 8'h08
`define WSFM_OFS_DATA_PORT 8'h0C
`define WSFM_OFS_PM_CS 8'h10
`define WSFM_OFS_IRQ_STAT 8'h14
`define WSFM_OFS_IRQ_MASK 8'h18
`define WSFM_OFS_MATCH 8'h1C

// Field positions
`define WSFM_CFG_SAMPLE_EN 28
`define WSFM_MODE_HI 28
`define WSFM_MODE_LO 25
`define WSFM_SEL_HI 8
`define WSFM_SEL_LO 3
`define WSFM_PM_EN 8
`define WSFM_PM_STATUS 15
`define WSFM_IRQ_WAKE 0
`define WSFM_IRQ_DONE 1

// Codes
`define WSFM_MODE_FIFO_TEST 4'h3
`define WSFM_SEL_TX 6'h32
`define WSFM_SEL_RX 6'h35
`define WSFM_SEL_PTR 6'h38
`define WSFM_PS_D3HOT 2'h3
`define WSFM_MASK_CHECK 2'h1
`define WSFM_MASK_END 2'h3

// Pointer reset port bits
`define WSFM_PTR_TXW_CLR 0
`define WSFM_PTR_TXR_CLR 1
`define WSFM_PTR_RXW_CLR 2
`define WSFM_PTR_RXR_CLR 3
`define WSFM_PTR_TXW_HALF 5
`define WSFM_PTR_RXW_HALF 6

// Storage geometry
`define WSFM_PTR_W 8
`define WSFM_PTR_HALF 8'h80
`define WSFM_LAST_BYTE 7'h7F

// Reset values
`define WSFM_RST_32 32'h00000000
`define WSFM_RST_PTR_PORT 7'h00

`endif

// File: rtl/wsfm_lane_cmp.v
`timescale 1ns/1ps
`include "wsfm_regs.vh"

// Four frames share a word, one per byte lane
module wsfm_lane_cmp (
   input wire [31:0] data_word,
   input wire [31:0] mask_word,
   input wire [7:0] rx_byte,
   output reg [3:0] lane_end,
   output reg [3:0] lane_bad
);
   integer i;
   reg [1:0] code;

   always @* begin
      code = 2'h0;
      lane_end = 4'h0;
      lane_bad = 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
         // Only the two low mask bits count; 00 and 10 are don't care
         code = mask_word[8*i +: 2];
         lane_end[i] = (code == `WSFM_MASK_END);
         lane_bad[i] = (code == `WSFM_MASK_CHECK) &&
            (data_word[8*i +: 8] != rx_byte);
      end
   end
endmodule

// File: rtl/wsfm_mem.v
`timescale 1ns/1ps
`include "wsfm_regs.vh"

// 256 words of 32 bits, one write port, registered read port
module wsfm_mem (
   input wire clk,
   input wire we,
   input wire [`WSFM_PTR_W-1:0] waddr,
   input wire [31:0] wdata,
   input wire [`WSFM_PTR_W-1:0] raddr,
   output reg [31:0] rdata
);
   reg [31:0] store [0:255];

   always @(posedge clk) begin
      if (we) begin
         store[waddr] <= wdata;
      end
      rdata <= store[raddr];
   end
endmodule

// File: rtl/wsfm_top.v
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "wsfm_regs.vh"

module wsfm_top (
   input wire clk,
   input wire reset,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output wire [31:0] rdata,
   input wire rx_valid,
   input wire [7:0] rx_byte,
   input wire rx_last,
   output wire rx_ready,
   output wire power_event_request_n_out,
   output wire power_event_request_n_oe,
   output wire irq
);
   localparam S_IDLE = 2'd0;
   localparam S_LO = 2'd1;
   localparam S_EV_LO = 2'd2;
   localparam S_EV_HI = 2'd3;

   localparam RD_REG = 2'd0;
   localparam RD_TX = 2'd1;
   localparam RD_RX = 2'd2;

   reg [31:0] device_specific_config;
   reg [31:0] operation_mode_reg;
   reg [31:0] sample_frame_access_select;
   reg [6:0] fifo_pointer_reset_port;
   reg [1:0] power_state;
   reg pme_en;
   reg pme_status;
   reg [1:0] irq_stat;
   reg [1:0] irq_mask;
   reg [7:0] match_vec;

   reg [`WSFM_PTR_W-1:0] tx_wr_ptr;
   reg [`WSFM_PTR_W-1:0] tx_rd_ptr;
   reg [`WSFM_PTR_W-1:0] rx_wr_ptr;
   reg [`WSFM_PTR_W-1:0] rx_rd_ptr;

   reg [1:0] state;
   reg [6:0] byte_idx;
   reg [7:0] cur_byte;
   reg cur_last;
   reg drain;
   reg [7:0] alive;
   reg [7:0] ended;
   reg [7:0] hit;

   reg [31:0] reg_rdata;
   reg [1:0] rd_kind;

   wire test_mode;
   wire [5:0] sel;
   wire active;
   wire port_wr;
   wire port_rd;
   wire tx_we;
   wire rx_we;
   wire [`WSFM_PTR_W-1:0] match_addr;
   wire [`WSFM_PTR_W-1:0] tx_raddr;
   wire [`WSFM_PTR_W-1:0] rx_raddr;
   wire [31:0] tx_dout;
   wire [31:0] rx_dout;
   wire [3:0] lane_end;
   wire [3:0] lane_bad;
   wire [7:0] upd_lo;
   wire [7:0] upd_hi;
   wire [7:0] alive_fin;
   wire [7:0] ended_fin;
   wire [7:0] hit_fin;
   wire [7:0] full_len;
   wire [7:0] final_hit;
   wire finish;
   wire wake_event;
   wire done_event;

   // Packs new {ended, alive} for one group of four frames
   function [7:0] frame_upd;
      input [3:0] alv;
      input [3:0] end_seen;
      input [3:0] le;
      input [3:0] lb;
      reg [3:0] live;
      begin
         live = alv & ~end_seen;
         frame_upd = {end_seen | (live & le), alv & ~(live & ~le & lb)};
      end
   endfunction

   function is_reg;
      input [7:0] a;
      input [7:0] ofs;
      begin
         is_reg = (a == ofs);
      end
   endfunction

   assign test_mode = (operation_mode_reg[`WSFM_MODE_HI:`WSFM_MODE_LO] ==
      `WSFM_MODE_FIFO_TEST);
   assign sel = sample_frame_access_select[`WSFM_SEL_HI:`WSFM_SEL_LO];
   // Matching only in hot sleep and never while software owns the FIFOs
   assign active = device_specific_config[`WSFM_CFG_SAMPLE_EN] &&
      (power_state == `WSFM_PS_D3HOT) && !test_mode;

   assign port_wr = wr && is_reg(addr, `WSFM_OFS_DATA_PORT) &&
      test_mode;
   assign port_rd = rd && is_reg(addr, `WSFM_OFS_DATA_PORT) &&
      test_mode;
   assign tx_we = port_wr && (sel == `WSFM_SEL_TX);
   assign rx_we = port_wr && (sel == `WSFM_SEL_RX);

   // Frames 0-3 at word i, frames 4-7 at word 128+i
   assign match_addr = (state == S_LO) ? {1'b0, byte_idx} :
      {1'b1, byte_idx};
   assign tx_raddr = test_mode ? tx_rd_ptr : match_addr;
   assign rx_raddr = test_mode ? rx_rd_ptr : match_addr;

   wsfm_mem u_mask_mem (
      .clk(clk),
      .we(tx_we),
      .waddr(tx_wr_ptr),
      .wdata(wdata),
      .raddr(tx_raddr),
      .rdata(tx_dout)
   );

   wsfm_mem u_data_mem (
      .clk(clk),
      .we(rx_we),
      .waddr(rx_wr_ptr),
      .wdata(wdata),
      .raddr(rx_raddr),
      .rdata(rx_dout)
   );

   wsfm_lane_cmp u_cmp (
      .data_word(rx_dout),
      .mask_word(tx_dout),
      .rx_byte(cur_byte),
      .lane_end(lane_end),
      .lane_bad(lane_bad)
   );

   assign upd_lo = frame_upd(alive[3:0], ended[3:0], lane_end, lane_bad);
   assign upd_hi = frame_upd(alive[7:4], ended[7:4], lane_end, lane_bad);
   assign alive_fin = {upd_hi[3:0], alive[3:0]};
   assign ended_fin = {upd_hi[7:4], ended[3:0]};
   assign hit_fin = {upd_hi[7:4] & ~ended[7:4], hit[3:0]} | hit;
   // A frame that ran all 128 bytes without mismatch also counts
   assign full_len = (byte_idx == `WSFM_LAST_BYTE) ?
      (alive_fin & ~ended_fin) : 8'h00;
   assign final_hit = hit_fin | full_len;
   assign finish = (state == S_EV_HI) &&
      (cur_last || byte_idx == `WSFM_LAST_BYTE ||
      (ended_fin | ~alive_fin) == 8'hFF);
   assign wake_event = finish && (final_hit != 8'h00);
   assign done_event = finish;

   assign rx_ready = (state == S_IDLE);

   // Byte-wise compare, three cycles per received byte
   always @(posedge clk) begin
      if (reset || !active) begin
         state <= S_IDLE;
         byte_idx <= 7'h00;
         cur_byte <= 8'h00;
         cur_last <= 1'b0;
         drain <= 1'b0;
         alive <= 8'hFF;
         ended <= 8'h00;
         hit <= 8'h00;
      end else begin
         case (state)
            S_IDLE: begin
               if (rx_valid) begin
                  if (drain) begin
                     drain <= !rx_last;
                  end else begin
                     cur_byte <= rx_byte;
                     cur_last <= rx_last;
                     state <= S_LO;
                  end
               end
            end
            S_LO: begin
               state <= S_EV_LO;
            end
            S_EV_LO: begin
               alive[3:0] <= upd_lo[3:0];
               ended[3:0] <= upd_lo[7:4];
               hit[3:0] <= hit[3:0] | (upd_lo[7:4] & ~ended[3:0]);
               state <= S_EV_HI;
            end
            S_EV_HI: begin
               state <= S_IDLE;
               if (finish) begin
                  byte_idx <= 7'h00;
                  alive <= 8'hFF;
                  ended <= 8'h00;
                  hit <= 8'h00;
                  // Rest of a packet that finishes before its last byte is swallowed
                  drain <= !cur_last;
               end else begin
                  byte_idx <= byte_idx + 7'h01;
                  alive <= alive_fin;
                  ended <= ended_fin;
                  hit <= hit_fin;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // FIFO pointers; a port write or read advances by one word
   always @(posedge clk) begin
      if (reset) begin
         tx_wr_ptr <= 8'h00;
         tx_rd_ptr <= 8'h00;
         rx_wr_ptr <= 8'h00;
         rx_rd_ptr <= 8'h00;
         fifo_pointer_reset_port <= `WSFM_RST_PTR_PORT;
      end else begin
         if (tx_we) begin
            tx_wr_ptr <= tx_wr_ptr + 8'h01;
         end
         if (rx_we) begin
            rx_wr_ptr <= rx_wr_ptr + 8'h01;
         end
         if (port_rd && sel == `WSFM_SEL_TX) begin
            tx_rd_ptr <= tx_rd_ptr + 8'h01;
         end
         if (port_rd && sel == `WSFM_SEL_RX) begin
            rx_rd_ptr <= rx_rd_ptr + 8'h01;
         end
         if (port_wr && sel == `WSFM_SEL_PTR) begin
            fifo_pointer_reset_port <= wdata[6:0];
            if (wdata[`WSFM_PTR_TXW_CLR]) begin
               tx_wr_ptr <= 8'h00;
            end else if (wdata[`WSFM_PTR_TXW_HALF]) begin
               tx_wr_ptr <= `WSFM_PTR_HALF;
            end
            if (wdata[`WSFM_PTR_TXR_CLR]) begin
               tx_rd_ptr <= 8'h00;
            end
            if (wdata[`WSFM_PTR_RXW_CLR]) begin
               rx_wr_ptr <= 8'h00;
            end else if (wdata[`WSFM_PTR_RXW_HALF]) begin
               rx_wr_ptr <= `WSFM_PTR_HALF;
            end
            if (wdata[`WSFM_PTR_RXR_CLR]) begin
               rx_rd_ptr <= 8'h00;
            end
         end
      end
   end

   // Software registers; hardware set wins over write-one-to-clear
   always @(posedge clk) begin
      if (reset) begin
         device_specific_config <= `WSFM_RST_32;
         operation_mode_reg <= `WSFM_RST_32;
         sample_frame_access_select <= `WSFM_RST_32;
         power_state <= 2'h0;
         pme_en <= 1'b0;
         pme_status <= 1'b0;
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
         match_vec <= 8'h00;
      end else begin
         if (wr && is_reg(addr, `WSFM_OFS_DEV_CFG)) begin
            device_specific_config <= wdata;
         end
         if (wr && is_reg(addr, `WSFM_OFS_OP_MODE)) begin
            operation_mode_reg <= wdata;
         end
         if (wr && is_reg(addr, `WSFM_OFS_ACC_SEL)) begin
            sample_frame_access_select <= wdata;
         end
         if (wr && is_reg(addr, `WSFM_OFS_PM_CS)) begin
            power_state <= wdata[1:0];
            pme_en <= wdata[`WSFM_PM_EN];
         end
         if (wr && is_reg(addr, `WSFM_OFS_IRQ_MASK)) begin
            irq_mask <= wdata[1:0];
         end
         if (wake_event) begin
            pme_status <= 1'b1;
         end else if (wr && is_reg(addr, `WSFM_OFS_PM_CS) &&
               wdata[`WSFM_PM_STATUS]) begin
            pme_status <= 1'b0;
         end
         if (wake_event) begin
            match_vec <= final_hit;
         end
         irq_stat[`WSFM_IRQ_WAKE] <= wake_event ||
            (irq_stat[`WSFM_IRQ_WAKE] && !(wr &&
            is_reg(addr, `WSFM_OFS_IRQ_STAT) && wdata[`WSFM_IRQ_WAKE]));
         irq_stat[`WSFM_IRQ_DONE] <= done_event ||
            (irq_stat[`WSFM_IRQ_DONE] && !(wr &&
            is_reg(addr, `WSFM_OFS_IRQ_STAT) && wdata[`WSFM_IRQ_DONE]));
      end
   end

   // Read path: register values captured, FIFO words from memory
   always @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 32'h00000000;
         rd_kind <= RD_REG;
      end else begin
         rd_kind <= RD_REG;
         reg_rdata <= 32'h00000000;
         if (rd) begin
            case (addr)
               `WSFM_OFS_DEV_CFG: reg_rdata <= device_specific_config;
               `WSFM_OFS_OP_MODE: reg_rdata <= operation_mode_reg;
               `WSFM_OFS_ACC_SEL: reg_rdata <= sample_frame_access_select;
               `WSFM_OFS_DATA_PORT: begin
                  if (port_rd && sel == `WSFM_SEL_TX) begin
                     rd_kind <= RD_TX;
                  end else if (port_rd && sel == `WSFM_SEL_RX) begin
                     rd_kind <= RD_RX;
                  end else if (port_rd && sel == `WSFM_SEL_PTR) begin
                     reg_rdata <= {25'h0000000, fifo_pointer_reset_port};
                  end
               end
               `WSFM_OFS_PM_CS: begin
                  reg_rdata <= {16'h0000, pme_status, 6'h00, pme_en,
                     6'h00, power_state};
               end
               `WSFM_OFS_IRQ_STAT: reg_rdata <= {30'h00000000, irq_stat};
               `WSFM_OFS_IRQ_MASK: reg_rdata <= {30'h00000000, irq_mask};
               `WSFM_OFS_MATCH: begin
                  reg_rdata <= {22'h000000, state, match_vec};
               end
               default: reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end

   assign rdata = (rd_kind == RD_TX) ? tx_dout :
      (rd_kind == RD_RX) ? rx_dout : reg_rdata;

   // Open drain: only ever pulls low
   assign power_event_request_n_out = 1'b0;
   assign power_event_request_n_oe = pme_en && pme_status;
   assign irq = |(irq_stat & irq_mask);
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
`include "wsfm_regs.vh"
module tb;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg rx_valid = 1'b0;
   reg [7:0] rx_byte = 8'h00;
   reg rx_last = 1'b0;
   wire [31:0] rdata;
   wire rx_ready;
   wire pin_out;
   wire pin_oe;
   wire irq;
   reg rd_q = 1'b0;
   reg rdy_smp = 1'b1;
   reg [31:0] expq[$];
   integer miscompares = 0;
   integer n_checks = 0;
   integer seed = 33;
   integer i;
   reg [7:0] x;
   reg [15:0] r16;
   wsfm_top i_wsfm_top (.clk(clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last),
      .rx_ready(rx_ready), .power_event_request_n_out(pin_out),
      .power_event_request_n_oe(pin_oe), .irq(irq));
   initial begin
      forever #25 clk = ~clk;
   end
   task check(input [31:0] seen, input [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // A gap cycle after each strobe keeps one assignment per time step
   task wreg(input [7:0] a, input [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task rreg(input [7:0] a, input [31:0] e);
      addr <= a;
      rd <= 1'b1;
      expq.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task sel(input [5:0] s);
      wreg(`WSFM_OFS_ACC_SEL, {23'h0, s, 3'h0});
   endtask
   task ptr(input [31:0] v);
      sel(`WSFM_SEL_PTR);
      wreg(`WSFM_OFS_DATA_PORT, v);
      wreg(`WSFM_OFS_DATA_PORT, 32'h0);
   endtask
   task put(input [5:0] s, input [31:0] a, input [31:0] b, input [31:0] c);
      sel(s);
      wreg(`WSFM_OFS_DATA_PORT, a);
      wreg(`WSFM_OFS_DATA_PORT, b);
      wreg(`WSFM_OFS_DATA_PORT, c);
   endtask
   task send(input [7:0] b, input l);
      rx_byte <= b;
      rx_last <= l;
      rx_valid <= 1'b1;
      do @(posedge clk); while (rdy_smp !== 1'b1);
   endtask
   // Third byte ends every frame, so the fourth falls in the drain
   task pkt(input [7:0] b0, input [7:0] b1);
      send(b0, 1'b0);
      send(b1, 1'b0);
      send(8'($random(seed)), 1'b0);
      send(8'($random(seed)), 1'b1);
      rx_valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task pins(input i_exp, input o_exp);
      @(negedge clk);
      check({30'h0, irq, pin_oe}, {30'h0, i_exp, o_exp});
      @(posedge clk);
   endtask
   always @(posedge clk) rd_q <= rd;
   always @(negedge clk) begin
      rdy_smp <= rx_ready;
      if (rd_q) begin
         check(rdata, expq.pop_front());
      end
   end
   initial begin
      #200000;
      miscompares = miscompares + 1;
      conclude;
   end
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 9; i = i + 1) begin
         rreg(8'(i * 4), 32'h0);
      end
      x = 8'($random(seed));
      r16 = 16'($random(seed));
      sel(`WSFM_SEL_PTR);
      wreg(`WSFM_OFS_DATA_PORT, 32'h7F);
      rreg(`WSFM_OFS_DATA_PORT, 32'h0);
      // Receive held idle while the buffers are loaded
      wreg(`WSFM_OFS_OP_MODE, 32'h06000000);
      rreg(`WSFM_OFS_DATA_PORT, 32'h0);
      wreg(`WSFM_OFS_DATA_PORT, 32'h0F);
      rreg(`WSFM_OFS_DATA_PORT, 32'h0F);
      wreg(`WSFM_OFS_DATA_PORT, 32'h0);
      put(`WSFM_SEL_RX, {4{x}}, {x ^ 8'h01, r16, x},
         $random(seed));
      ptr(32'h40);
      put(`WSFM_SEL_RX, {4{x ^ 8'h80}}, $random(seed), $random(seed));
      put(`WSFM_SEL_TX, 32'h05010101, 32'h01FE0001, 32'hFF030703);
      ptr(32'h20);
      put(`WSFM_SEL_TX, 32'h05010101, 32'h01FE0001, 32'hFF030703);
      ptr(32'h08);
      sel(`WSFM_SEL_RX);
      rreg(`WSFM_OFS_DATA_PORT, {4{x}});
      rreg(`WSFM_OFS_DATA_PORT, {x ^ 8'h01, r16, x});
      sel(`WSFM_SEL_TX);
      rreg(`WSFM_OFS_DATA_PORT, 32'h05010101);
      wreg(`WSFM_OFS_OP_MODE, 32'h0);
      wreg(`WSFM_OFS_PM_CS, 32'h103);
      wreg(`WSFM_OFS_IRQ_MASK, 32'h3);
      pkt(x, x);
      rreg(`WSFM_OFS_IRQ_STAT, 32'h0);
      rreg(`WSFM_OFS_MATCH, 32'h0);
      wreg(`WSFM_OFS_DEV_CFG, 32'h10000000);
      pkt(x, x);
      rreg(`WSFM_OFS_MATCH, 32'h07);
      rreg(`WSFM_OFS_IRQ_STAT, 32'h3);
      rreg(`WSFM_OFS_PM_CS, 32'h8103);
      pins(1'b1, 1'b1);
      wreg(`WSFM_OFS_PM_CS, 32'h8103);
      wreg(`WSFM_OFS_IRQ_STAT, 32'h3);
      pins(1'b0, 1'b0);
      pkt(x ^ 8'h01, x);
      rreg(`WSFM_OFS_IRQ_STAT, 32'h2);
      // Match field keeps the frames of the last wake
      rreg(`WSFM_OFS_MATCH, 32'h07);
      wreg(`WSFM_OFS_IRQ_MASK, 32'h0);
      pins(1'b0, 1'b0);
      conclude;
   end
endmodule

// File: verification/wsfm_top_sva.sv
`timescale 1ns/1ps
`include "wsfm_regs.vh"
module wsfm_top_sva (
   input wire clk,
   input wire reset,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata,
   input wire rx_valid,
   input wire [7:0] rx_byte,
   input wire rx_last,
   input wire rx_ready,
   input wire power_event_request_n_out,
   input wire power_event_request_n_oe,
   input wire irq
);
   reg test_mode;
   // Mirror of the mode field; the ports alone cannot show it
   always @(posedge clk) begin
      if (reset) begin
         test_mode <= 1'b0;
      end else if (wr && addr == `WSFM_OFS_OP_MODE) begin
         test_mode <= wdata[28:25] == `WSFM_MODE_FIFO_TEST;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_port_refused: assert property (
      rd && addr == `WSFM_OFS_DATA_PORT && !test_mode |=> rdata == 32'h0)
      else $error("data port read outside test mode not zero");
   a_busy_three: assert property (
      $fell(rx_ready) |-> !rx_ready ##1 !rx_ready ##1 !rx_ready ##1 rx_ready)
      else $error("receive busy span not three cycles");
   a_take_cause: assert property (
      $fell(rx_ready) |-> $past(rx_valid && !test_mode))
      else $error("receive busy without a taken byte");
   a_pin_value: assert property (
      power_event_request_n_out == 1'b0)
      else $error("request pin pull value not low");
   a_oe_cause: assert property (
      $rose(power_event_request_n_oe) |->
         $rose(rx_ready) || $past(wr && addr == `WSFM_OFS_PM_CS))
      else $error("request pin driven without cause");
   a_irq_cause: assert property (
      $rose(irq) |->
         $rose(rx_ready) || $past(wr && addr == `WSFM_OFS_IRQ_MASK))
      else $error("interrupt raised without cause");
   a_irq_masked: assert property (
      wr && addr == `WSFM_OFS_IRQ_MASK && wdata[1:0] == 2'h0 && rx_ready
      |=> !irq)
      else $error("interrupt high with all sources masked");
   a_oe_clear: assert property (
      wr && addr == `WSFM_OFS_PM_CS && wdata[`WSFM_PM_STATUS] && rx_ready
      |=> !power_event_request_n_oe)
      else $error("request pin still driven after status clear");
endmodule
bind wsfm_top wsfm_top_sva i_wsfm_top_sva (.clk(clk), .reset(reset),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last),
   .rx_ready(rx_ready),
   .power_event_request_n_out(power_event_request_n_out),
   .power_event_request_n_oe(power_event_request_n_oe), .irq(irq));
